/* include/pec_ctr_if.sv */
// ---------------------------------------------------------------
// Carrier between the top and one counter slice
// ---------------------------------------------------------------
interface pec_ctr_if;
  logic        ctl_wr;
  logic        cnt_wr;
  logic        root_wr;
  logic [31:0] wdata;
  logic        count_en;
  logic [31:0] ctl;
  logic [31:0] cnt;
  logic        irq;

  modport top (output ctl_wr, cnt_wr, root_wr, wdata, count_en,
               input  ctl, cnt, irq);
  modport ctr (input  ctl_wr, cnt_wr, root_wr, wdata, count_en,
               output ctl, cnt, irq);
endinterface

/* include/pec_pkg.sv */
// ---------------------------------------------------------------
// Performance event counter constants
// ---------------------------------------------------------------
package pec_pkg;

  // Register selects on the coprocessor move path
  localparam int unsigned SEL_W      = 3;
  localparam logic [2:0]  SEL_C0_CTL = 3'h0;
  localparam logic [2:0]  SEL_C0_CNT = 3'h1;
  localparam logic [2:0]  SEL_C1_CTL = 3'h2;
  localparam logic [2:0]  SEL_C1_CNT = 3'h3;

  // Widths
  localparam int unsigned DW       = 32;
  localparam int unsigned NUM_CTR  = 2;
  localparam int unsigned EVT_W    = 6;
  localparam int unsigned NUM_EVT  = 64;
  localparam int unsigned IRQ_SEL_W = 3;
  localparam int unsigned NUM_IRQ  = 8;

  // Control field positions
  localparam int unsigned BIT_NEXT_PAIR = 31;
  localparam int unsigned CTX_MSB       = 24;
  localparam int unsigned CTX_LSB       = 23;
  localparam int unsigned EXT_MSB       = 14;
  localparam int unsigned EXT_LSB       = 11;
  localparam int unsigned EVT_MSB       = 10;
  localparam int unsigned EVT_LSB       = 5;
  localparam int unsigned BIT_IRQ_MASK  = 4;
  localparam int unsigned BIT_USER      = 3;
  localparam int unsigned BIT_KERNEL    = 1;
  localparam int unsigned BIT_EXC_LVL   = 0;
  localparam int unsigned CNT_MSB       = 31;

  // Writable control bits, and the bits only root may write
  localparam logic [31:0] CTL_WR_MASK   = 32'h0180_7ffb;
  localparam logic [31:0] CTL_ROOT_MASK = 32'h0180_0000;
  localparam logic [31:0] CTL_RESET     = 32'h0000_0000;
  localparam logic [31:0] CNT_RESET     = 32'h0000_0000;
  localparam logic [31:0] CNT_ONE       = 32'h0000_0001;
  localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;

  // Counter 0 has a further pair above it, counter 1 is the last
  localparam logic [1:0]  NEXT_PAIR_PRESET = 2'h1;

  // Events filtered by privilege bits; clear bits are free-running
  localparam logic [63:0] MODE_QUAL_C0 = 64'hffff_ef7f_fdfb_fffe;
  localparam logic [63:0] MODE_QUAL_C1 = 64'hffff_ffff_fdff_fffe;

  // Guest/root context filter encodings
  typedef enum logic [1:0] {
    PEC_CTX_ROOT       = 2'h0,
    PEC_CTX_ROOT_INTV  = 2'h1,
    PEC_CTX_GUEST      = 2'h2,
    PEC_CTX_GUEST_INTV = 2'h3
  } pec_ctx_t;

endpackage

/* src/pec_counter.sv */
// ---------------------------------------------------------------
// One control and count pair
// ---------------------------------------------------------------
module pec_counter (
  input  wire logic sys_clk_i,
  input  wire logic arst_n_i,
  pec_ctr_if.ctr    bus
);

  logic [31:0] ctl_reg;
  logic [31:0] ctl_next;
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic [31:0] wr_mask;

  // Context field only lands on a root write
  assign wr_mask = bus.root_wr ? pec_pkg::CTL_WR_MASK :
                   (pec_pkg::CTL_WR_MASK & ~pec_pkg::CTL_ROOT_MASK);
  assign ctl_next = bus.ctl_wr ? ((ctl_reg & ~wr_mask) |
                                  (bus.wdata & wr_mask))
                               : ctl_reg;
  // Software write beats a same-cycle event
  assign cnt_next = bus.cnt_wr   ? bus.wdata :
                    bus.count_en ? cnt_reg + pec_pkg::CNT_ONE
                                 : cnt_reg;

  // Reset leaves every enable clear, so nothing counts
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctl_reg <= pec_pkg::CTL_RESET;
      cnt_reg <= pec_pkg::CNT_RESET;
    end else begin
      ctl_reg <= ctl_next;
      cnt_reg <= cnt_next;
    end
  end

  // Interrupt follows the count MSB, so a wrap clears it
  assign bus.irq = cnt_reg[pec_pkg::CNT_MSB] &
                   ctl_reg[pec_pkg::BIT_IRQ_MASK];
  assign bus.ctl = ctl_reg;
  assign bus.cnt = cnt_reg;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);

  a_count_step: assert property (
    !bus.cnt_wr && bus.count_en |=> cnt_reg == $past(cnt_reg) + 32'h1)
    else $error("count did not advance by one");
  a_wrap_clears: assert property (
    !bus.cnt_wr && bus.count_en && (&cnt_reg) |=> !bus.irq)
    else $error("interrupt stayed after wrap");
  a_ctx_root_only: assert property (
    bus.ctl_wr && !bus.root_wr |=>
      ctl_reg[24:23] == $past(ctl_reg[24:23]))
    else $error("context written outside root");

endmodule // pec_counter

/* src/pec_top.sv */
// Overview of operation
// - Select 0..3 reach counter0 control, count, counter1 control, count.
// - Each count is 32-bit read/write, advancing by one per event.
// - Counters run independently, each watching its own selected event.
// - Interrupt is OR of each count MSB ANDed with its enable.
// - Interrupt is routed internally to the line picked by a field.
// - Counting carries on unchanged while the interrupt is raised.
// - Interrupt drops on wrap to zero or a write with MSB clear.
// - With a clock gater, counters stop in sleep; cycles go uncounted.
// - Control bit 31 is a read-only flag: a further pair exists.
// - Context field resets 0, root-writable only, reads 0 elsewhere.
// - Context 0/1 count in root context, 2/3 in guest context.
// - Event code bits 10:5 and extension bits 14:11 are read/write.
// - Control bit 4 enables the interrupt; resets to 0.
// - Control bit 1 allows kernel counting when both level flags clear.
// - Control bit 0 allows counting at exception level, fault level clear.
// - No counting in debug mode or with the fault level flag set.
// - After reset counters idle until software enables counting.
// - Reserved control bits read zero; software writes zeros.
module pec_top (
  input  wire logic        sys_clk_i,
  input  wire logic        arst_n_i,
  // Coprocessor register move port
  input  wire logic [2:0]  reg_sel_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [31:0] reg_wdata_i,
  output logic      [31:0] reg_rdata_o,
  // Processor state
  input  wire logic        root_mode_i,
  input  wire logic        guest_ctx_i,
  input  wire logic        root_intv_i,
  input  wire logic        user_mode_i,
  input  wire logic        kernel_mode_i,
  input  wire logic        exc_level_i,
  input  wire logic        fault_level_flag_i,
  input  wire logic        debug_mode_i,
  // Raw event strobes, one bit per event code
  input  wire logic [63:0] evt0_i,
  input  wire logic [63:0] evt1_i,
  // Interrupt routing
  input  wire logic [2:0]  perf_irq_line_select_i,
  output logic             perf_irq_o,
  output logic      [7:0]  perf_irq_lines_o
);

  // ---------------------------------------------------------------
  // Register select decode
  // ---------------------------------------------------------------
  pec_ctr_if ctr_if [pec_pkg::NUM_CTR] ();

  logic [63:0] evt_vec    [pec_pkg::NUM_CTR];
  logic [63:0] mode_qual  [pec_pkg::NUM_CTR];
  logic [1:0]  ctl_sel_hit;
  logic [1:0]  cnt_sel_hit;
  logic [1:0]  irq_vec;
  logic [31:0] ctl_view   [pec_pkg::NUM_CTR];
  logic [31:0] rdata_mux;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        sel_mapped;
  logic        halt_all;
  logic        lvl_base;
  logic        lvl_exc;

  // Select values 0..3 each reach exactly one register; 4..7 reach none
  assign ctl_sel_hit[0] = reg_sel_i == pec_pkg::SEL_C0_CTL;
  assign cnt_sel_hit[0] = reg_sel_i == pec_pkg::SEL_C0_CNT;
  assign ctl_sel_hit[1] = reg_sel_i == pec_pkg::SEL_C1_CTL;
  assign cnt_sel_hit[1] = reg_sel_i == pec_pkg::SEL_C1_CNT;
  assign sel_mapped     = |{ctl_sel_hit, cnt_sel_hit};

  assign evt_vec[0]   = evt0_i;
  assign evt_vec[1]   = evt1_i;
  assign mode_qual[0] = pec_pkg::MODE_QUAL_C0;
  assign mode_qual[1] = pec_pkg::MODE_QUAL_C1;

  // ---------------------------------------------------------------
  // Global privilege state
  // ---------------------------------------------------------------
  // Debug or fault level freezes both counters outright
  assign halt_all = debug_mode_i | fault_level_flag_i;
  // Plain user/kernel counting needs both level flags low
  assign lvl_base = !exc_level_i && !fault_level_flag_i;
  // Exception-level counting needs the fault flag low
  assign lvl_exc  = exc_level_i && !fault_level_flag_i;

  // ---------------------------------------------------------------
  // Per-counter slices
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < pec_pkg::NUM_CTR; g++) begin : g_ctr
      logic [5:0] evt_code;
      logic [1:0] ctx_code;
      logic       evt_seen;
      logic       is_qual;
      logic       any_enable;
      logic       user_ok;
      logic       kern_ok;
      logic       exc_ok;
      logic       priv_ok;
      logic       ctx_ok;

      assign evt_code = ctr_if[g].ctl[pec_pkg::EVT_MSB:pec_pkg::EVT_LSB];
      assign ctx_code = ctr_if[g].ctl[pec_pkg::CTX_MSB:pec_pkg::CTX_LSB];
      // Only the event named in this slice's own control counts
      assign evt_seen = evt_vec[g][evt_code];
      assign is_qual  = mode_qual[g][evt_code];

      // Privilege qualifiers
      assign user_ok  = ctr_if[g].ctl[pec_pkg::BIT_USER] &
                        user_mode_i & lvl_base;
      assign kern_ok  = ctr_if[g].ctl[pec_pkg::BIT_KERNEL] &
                        kernel_mode_i & lvl_base;
      assign exc_ok   = ctr_if[g].ctl[pec_pkg::BIT_EXC_LVL] &
                        lvl_exc;
      // Free-running events still need some enable set after reset
      assign any_enable = ctr_if[g].ctl[pec_pkg::BIT_USER] |
                          ctr_if[g].ctl[pec_pkg::BIT_KERNEL] |
                          ctr_if[g].ctl[pec_pkg::BIT_EXC_LVL];
      assign priv_ok  = is_qual ? (user_ok | kern_ok | exc_ok)
                                : any_enable;

      // Guest/root context filter
      always_comb begin
        case (pec_pkg::pec_ctx_t'(ctx_code))
          pec_pkg::PEC_CTX_ROOT:
            ctx_ok = !guest_ctx_i && !root_intv_i;
          pec_pkg::PEC_CTX_ROOT_INTV:
            ctx_ok = root_intv_i;
          pec_pkg::PEC_CTX_GUEST:
            ctx_ok = guest_ctx_i && !root_intv_i;
          pec_pkg::PEC_CTX_GUEST_INTV:
            ctx_ok = guest_ctx_i || root_intv_i;
          default:
            ctx_ok = 1'b0;
        endcase
      end

      // Interrupt state plays no part here, so counting never stalls
      assign ctr_if[g].count_en = evt_seen & priv_ok & ctx_ok &
                                  !halt_all;
      assign ctr_if[g].ctl_wr   = reg_wr_i & ctl_sel_hit[g];
      assign ctr_if[g].cnt_wr   = reg_wr_i & cnt_sel_hit[g];
      assign ctr_if[g].root_wr  = root_mode_i;
      assign ctr_if[g].wdata    = reg_wdata_i;
      assign irq_vec[g]         = ctr_if[g].irq;

      // Read view: preset flag on top, context hidden outside root
      assign ctl_view[g] = {pec_pkg::NEXT_PAIR_PRESET[g],
                            ctr_if[g].ctl[30:25],
                            root_mode_i ? ctx_code : 2'h0,
                            ctr_if[g].ctl[22:0]};

      pec_counter u_ctr (
        .sys_clk_i (sys_clk_i),
        .arst_n_i  (arst_n_i),
        .bus       (ctr_if[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  // Unused selects answer zero rather than aliasing
  assign rdata_mux =
    ctl_sel_hit[0] ? ctl_view[0]     :
    cnt_sel_hit[0] ? ctr_if[0].cnt   :
    ctl_sel_hit[1] ? ctl_view[1]     :
    cnt_sel_hit[1] ? ctr_if[1].cnt   :
                     pec_pkg::ZERO_WORD;
  assign rdata_next = reg_rd_i ? rdata_mux : rdata_reg;

  // Read data held until the next read
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_reg <= pec_pkg::ZERO_WORD;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata_o = rdata_reg;

  // ---------------------------------------------------------------
  // Interrupt combine and routing
  // ---------------------------------------------------------------
  // Gated clock in sleep is outside this block; no extra logic here
  assign perf_irq_o = |irq_vec;

  // One-hot fan-out saves an external pin join
  generate
    for (g = 0; g < pec_pkg::NUM_IRQ; g++) begin : g_irq
      assign perf_irq_lines_o[g] = perf_irq_o &&
        (perf_irq_line_select_i == 3'(g));
    end
  endgenerate

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);

  a_sel_count0: assert property (
    reg_wr_i && reg_sel_i == 3'h1 |=> ctr_if[0].cnt == $past(reg_wdata_i))
    else $error("select 1 did not load counter 0 value");

  a_sel_ctl1: assert property (
    reg_wr_i && reg_sel_i == 3'h2 |=>
      ctr_if[1].ctl[14:0] == ($past(reg_wdata_i[14:0]) & 15'h7ffb))
    else $error("select 2 did not load counter 1 control");

  a_irq_combine: assert property (
    perf_irq_o == ((ctr_if[0].cnt[31] & ctr_if[0].ctl[4]) |
                   (ctr_if[1].cnt[31] & ctr_if[1].ctl[4])))
    else $error("interrupt output not OR of masked MSBs");

  a_irq_route: assert property (
    perf_irq_o |-> perf_irq_lines_o == (8'h01 << perf_irq_line_select_i))
    else $error("interrupt not on selected line");

  a_irq_keeps_count: assert property (
    perf_irq_o && !reg_wr_i && ctr_if[0].count_en
      |=> ctr_if[0].cnt == $past(ctr_if[0].cnt) + 32'h1)
    else $error("counting stalled while interrupt raised");

  a_write_clears: assert property (
    reg_wr_i && reg_sel_i == 3'h1 && !reg_wdata_i[31] |=> !ctr_if[0].irq)
    else $error("msb-clear write kept interrupt");

  a_preset_flag: assert property (
    reg_rd_i && reg_sel_i == 3'h0 |=> reg_rdata_o[31])
    else $error("counter 0 preset flag not set");

  a_ctx_hidden: assert property (
    reg_rd_i && !root_mode_i && reg_sel_i == 3'h2
      |=> reg_rdata_o[24:23] == 2'h0)
    else $error("context field visible outside root");

  a_reserved_zero: assert property (
    reg_rd_i && reg_sel_i[2:1] == 2'h0 && !reg_sel_i[0]
      |=> reg_rdata_o[30:25] == 6'h0 && reg_rdata_o[22:15] == 8'h0
          && reg_rdata_o[2] == 1'b0)
    else $error("reserved control bits read nonzero");

  a_halt_freeze: assert property (
    (debug_mode_i || fault_level_flag_i) && !reg_wr_i
      |=> $stable(ctr_if[0].cnt) && $stable(ctr_if[1].cnt))
    else $error("counter moved in debug or fault level");

  a_user_gate: assert property (
    !ctr_if[0].ctl[3] && !ctr_if[0].ctl[1] && !ctr_if[0].ctl[0]
      |-> !ctr_if[0].count_en)
    else $error("counter 0 counted with no privilege enabled");

  a_unmapped_zero: assert property (
    reg_rd_i && reg_sel_i[2] |=> reg_rdata_o == 32'h0)
    else $error("unmapped select read nonzero");

  c_irq_seen:   cover property (perf_irq_o);
  c_both_count: cover property (ctr_if[0].count_en && ctr_if[1].count_en);
  c_wrap:       cover property (ctr_if[0].cnt == 32'hffff_ffff
                                ##1 ctr_if[0].cnt == 32'h0);
  c_guest_ctx:  cover property (guest_ctx_i && ctr_if[1].count_en);

endmodule // pec_top

/* tb/pec_core_model.sv */
// ---------------------------------------------------------------
// Core side: coprocessor register moves
// ---------------------------------------------------------------
module pec_core_model (
  input  wire logic        sys_clk_i,
  input  wire logic [31:0] reg_rdata_i,
  output logic      [2:0]  reg_sel_o,
  output logic             reg_wr_o,
  output logic             reg_rd_o,
  output logic      [31:0] reg_wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero
  initial begin
    reg_sel_o   = 3'h0;
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_wdata_o = 32'h0000_0000;
  end

  // One write move, strobe held across exactly one rising edge
  task automatic wr(input logic [2:0] s, input logic [31:0] d);
    logic is_ctl;
    is_ctl = (s == pec_pkg::SEL_C0_CTL) || (s == pec_pkg::SEL_C1_CTL);
    @(negedge sys_clk_i);
    reg_sel_o   = s;
    reg_wr_o    = 1'b1;
    reg_wdata_o = is_ctl ? (d & pec_pkg::CTL_WR_MASK) : d;
    @(negedge sys_clk_i);
    reg_wr_o    = 1'b0;
    reg_wdata_o = ~reg_wdata_o; // No stale data once released
  endtask

  // One read move; data settles after the taking edge
  task automatic rd(input logic [2:0] s, output logic [31:0] d);
    @(negedge sys_clk_i);
    reg_sel_o = s;
    reg_rd_o  = 1'b1;
    @(negedge sys_clk_i);
    reg_rd_o  = 1'b0;
    d         = reg_rdata_i;
  endtask
endmodule // pec_core_model

/* tb/perf_event_counters_tb.sv */
// ---------------------------------------------------------------
// Self-checking bench
// ---------------------------------------------------------------
module perf_event_counters_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        sys_clk_i = 1'b0;
  logic        arst_n_i  = 1'b0;
  logic [2:0]  sel;
  logic        wr, rd, irq;
  logic [31:0] wdata, rdata, got, e0, e1, c0, c1;
  logic        root = 1'b1, guest = 1'b0, intv = 1'b0, user = 1'b0;
  logic        kern = 1'b0, exc = 1'b0, flt = 1'b0, dbg = 1'b0;
  logic [63:0] evt0 = 64'h0, evt1 = 64'h0;
  logic [2:0]  lsel = 3'h0;
  logic [7:0]  lines;
  logic [31:0] seed = 32'h0000_0034;
  int          err_count = 0, checks = 0, cyc = 0;

  always #2 sys_clk_i = ~sys_clk_i;

  pec_core_model core (.sys_clk_i(sys_clk_i), .reg_rdata_i(rdata),
    .reg_sel_o(sel), .reg_wr_o(wr), .reg_rd_o(rd), .reg_wdata_o(wdata));

  pec_top dut (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
    .reg_sel_i(sel), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .root_mode_i(root), .guest_ctx_i(guest),
    .root_intv_i(intv), .user_mode_i(user), .kernel_mode_i(kern),
    .exc_level_i(exc), .fault_level_flag_i(flt), .debug_mode_i(dbg),
    .evt0_i(evt0), .evt1_i(evt1), .perf_irq_line_select_i(lsel),
    .perf_irq_o(irq), .perf_irq_lines_o(lines));

  // Xorshift source, fixed start so runs repeat
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Expected increment for one counter in the current cycle
  function automatic logic inc_exp(input logic [31:0] c,
                                   input logic [63:0] q,
                                   input logic [63:0] ev);
    logic pm, pa, cx;
    pa = c[3] | c[1] | c[0];
    pm = (c[3] & user & !exc) | (c[1] & kern & !exc) | (c[0] & exc);
    case (c[24:23])
      2'h0:    cx = !guest & !intv;
      2'h1:    cx = intv;
      2'h2:    cx = guest & !intv;
      default: cx = guest | intv;
    endcase
    return ev[c[10:5]] & (q[c[10:5]] ? pm : pa) & cx & !dbg & !flt;
  endfunction

  // Compare and tally
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("FAIL %0t got %h expected %h", $time, g, e);
    end
  endtask

  // Random processor state and events; tracks expected counts
  task automatic churn(input int n);
    logic [31:0] r;
    repeat (n) begin
      @(negedge sys_clk_i);
      r = rnd();
      {guest, intv, user, kern, exc} = r[4:0];
      root = r[5];
      dbg  = (r[9:6] == 4'h0);
      flt  = (r[13:10] == 4'h0);
      evt0 = {rnd(), rnd()};
      evt1 = {rnd(), rnd()};
      e0 = e0 + 32'(inc_exp(c0, pec_pkg::MODE_QUAL_C0, evt0));
      e1 = e1 + 32'(inc_exp(c1, pec_pkg::MODE_QUAL_C1, evt1));
    end
    @(negedge sys_clk_i);
    evt0 = 64'h0;
    evt1 = 64'h0;
    root = 1'b1;
  endtask

  // Cycle event on counter g for n cycles
  task automatic pulse(input logic g, input int n);
    @(negedge sys_clk_i);
    if (g) evt1[0] = 1'b1;
    else evt0[0] = 1'b1;
    repeat (n) @(negedge sys_clk_i);
    evt0[0] = 1'b0;
    evt1[0] = 1'b0;
  endtask

  // Verdict and end of run
  task automatic final_report();
    if (err_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Hang guard
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 6000) begin
      err_count++;
      final_report();
    end
  end

  // Main sequence
  initial begin
    logic [2:0] cs;
    repeat (12) @(negedge sys_clk_i);
    arst_n_i = 1'b1;
    c0 = 32'h0; c1 = 32'h0; e0 = 32'h0; e1 = 32'h0;
    churn(20);
    core.rd(3'h1, got); chk(got, 32'h0);
    core.rd(3'h3, got); chk(got, 32'h0);
    core.rd(3'h0, got); chk(got, 32'h8000_0000);
    core.rd(3'h2, got); chk(got, 32'h0);
    // Context field is written and seen only from root mode
    root = 1'b0;
    core.wr(3'h0, 32'hffff_ffff);
    root = 1'b1;
    core.rd(3'h0, got);
    chk(got, 32'h8000_0000 | (pec_pkg::CTL_WR_MASK &
        ~pec_pkg::CTL_ROOT_MASK));
    core.wr(3'h0, 32'hffff_ffff);
    core.rd(3'h0, got);
    chk(got, 32'h8000_0000 | pec_pkg::CTL_WR_MASK);
    root = 1'b0;
    core.rd(3'h0, got); chk(got, 32'h8000_7ffb);
    root = 1'b1;
    // Random rounds: controls, counts, unmapped selects, counting
    repeat (5) begin
      c0 = rnd() & pec_pkg::CTL_WR_MASK & 32'hffff_ffef;
      c1 = rnd() & pec_pkg::CTL_WR_MASK & 32'hffff_ffef;
      e0 = rnd() & 32'h0fff_ffff;
      e1 = rnd() & 32'h0fff_ffff;
      core.wr(3'h0, c0); core.wr(3'h1, e0);
      core.wr(3'h2, c1); core.wr(3'h3, e1);
      core.wr(3'h4 | 3'(rnd() & 32'h3), 32'hffff_ffff);
      core.rd(3'h4 | 3'(rnd() & 32'h3), got); chk(got, 32'h0);
      core.rd(3'h0, got); chk(got, c0 | 32'h8000_0000);
      core.rd(3'h2, got); chk(got, c1);
      // Outside root the context field must read as zero
      root = 1'b0;
      core.rd(3'h2, got);
      chk(got, c1 & ~pec_pkg::CTL_ROOT_MASK);
      root = 1'b1;
      churn(150);
      core.rd(3'h1, got);
      chk(got, e0);
      core.rd(3'h3, got);
      chk(got, e1);
    end
    // Interrupt raise, mask, wrap and software clear per counter
    user = 1'b1; kern = 1'b0; exc = 1'b0; flt = 1'b0; dbg = 1'b0;
    guest = 1'b0; intv = 1'b0;
    for (int g = 0; g < 2; g++) begin
      cs = 3'(2 * g);
      core.wr(cs, 32'h0000_0018);
      core.wr(cs + 3'h1, 32'h7fff_ffff);
      chk({31'h0, irq}, 32'h0);
      pulse(g[0], 1);
      chk({31'h0, irq}, 32'h1);
      for (int s = 0; s < 8; s++) begin
        // Change the line select only between rising edges
        @(negedge sys_clk_i);
        lsel = 3'(s);
        #1;
        chk({24'h0, lines}, 32'h1 << s);
      end
      pulse(g[0], 5);
      core.rd(cs + 3'h1, got); chk(got, 32'h8000_0005);
      core.wr(cs, 32'h0000_0008);
      chk({31'h0, irq}, 32'h0);
      core.wr(cs, 32'h0000_0018);
      core.wr(cs + 3'h1, 32'hffff_ffff);
      chk({31'h0, irq}, 32'h1);
      pulse(g[0], 1);
      chk({31'h0, irq}, 32'h0);
      core.rd(cs + 3'h1, got); chk(got, 32'h0);
      core.wr(cs + 3'h1, 32'h8000_0000);
      chk({31'h0, irq}, 32'h1);
      core.wr(cs + 3'h1, 32'h0000_0005);
      chk({31'h0, irq}, 32'h0);
    end
    final_report();
  end
endmodule // perf_event_counters_tb
